/* logic/sepm_top.sv */
// Strap capture and EEPROM pin multiplexer with an AXI4-Lite register slave.
// Assumes straps and the EEPROM data input arrive asynchronously from pins
// and the MII monitor sources are already on aclk.
// Contract
// - speed strap picks default speed, duplex, autoneg; here duplex is half for both strap levels
// - sample speed strap at reset release, hold
// - width strap captured at release, high 32-bit
// - data pin is bidirectional EEPROM data line
// - data pin may be GENERAL_OUTPUT_3 or TX monitor
// - data pin alternate role forces select inactive
// - clock pin may be GENERAL_OUTPUT_4 or RX monitor
// - clock pin alternate role forces select inactive
// - general outputs are output-only, never inputs
// - dedicated EEPROM select output drives memory
// - clock pin normally drives EEPROM serial clock
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module sepm_top (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Strap pins
	input  wire logic                speed_strap,
	input  wire logic                bus_width_strap,
	// Shared EEPROM data pin
	input  wire logic                eeprom_data_io_i,
	output logic                     eeprom_data_io_o,
	output logic                     eeprom_data_io_oe,
	// EEPROM clock and select
	output logic                     eeprom_serial_clock,
	output logic                     eeprom_select,
	// Internal MII monitor sources
	input  wire sepm_pkg::sepm_mii_t mii,
	// Latched defaults for MAC, PHY and host bus
	output sepm_pkg::sepm_strap_t    strap
);

	// Timing overview for whoever integrates this block:
	// - every output below comes straight from a flip-flop of the state record,
	//   so pins and bus answers change only just after a rising edge of aclk;
	// - a register write lands one edge after both halves are held, and the
	//   pins follow one further edge later;
	// - straps are latched at the third edge after reset is released, once the
	//   two-stage pin synchronisers have settled on the released levels;
	// - the MII monitor sources are taken as already on aclk and reach the
	//   shared pins one edge late, which bounds the monitor at half aclk.
	// All state of the block
	typedef struct packed {
		logic [1:0]                 rst_seen;
		logic [1:0]                 spd_sync;
		logic [1:0]                 wid_sync;
		logic [1:0]                 din_sync;
		sepm_pkg::sepm_strap_t      strap;
		sepm_pkg::sepm_data_mode_t  data_mode;
		sepm_pkg::sepm_clk_mode_t   clk_mode;
		logic                       general_output_3;
		logic                       general_output_4;
		logic                       ee_sel;
		logic                       ee_clk;
		logic                       ee_dout;
		logic                       ee_doe;
		logic                       aw_held;
		logic [7:0]                 aw_addr;
		logic                       w_held;
		logic [31:0]                w_data;
		logic [3:0]                 w_strb;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
		sepm_pkg::sepm_pins_t       pins;
	} sepm_state_t;

	sepm_state_t st;       // Registered state
	sepm_state_t next_st;  // Next state

	logic [31:0] pin_ctrl_word;  // Read view of pin control
	logic [31:0] ee_ctrl_word;   // Read view of EEPROM control
	logic [31:0] strap_word;     // Read view of strap status
	logic [31:0] pin_stat_word;  // Read view of pin levels

	// The read views gather register fields into bus words in one place,
	// so the read decoder only selects a word. Unused bits read as zero.
	// Status words show what the pins carry now, one edge behind the
	// control registers that command them.
	// Register read views
	always_comb begin
		pin_ctrl_word = 32'h0000_0000;
		pin_ctrl_word[sepm_pkg::DATA_MODE_LSB +: 2] = st.data_mode;
		pin_ctrl_word[sepm_pkg::CLK_MODE_LSB +: 2]  = st.clk_mode;
		pin_ctrl_word[sepm_pkg::GENERAL_OUTPUT_3_BIT]           = st.general_output_3;
		pin_ctrl_word[sepm_pkg::GENERAL_OUTPUT_4_BIT]           = st.general_output_4;
		ee_ctrl_word = 32'h0000_0000;
		ee_ctrl_word[sepm_pkg::EE_SEL_BIT]  = st.ee_sel;
		ee_ctrl_word[sepm_pkg::EE_CLK_BIT]  = st.ee_clk;
		ee_ctrl_word[sepm_pkg::EE_DOUT_BIT] = st.ee_dout;
		ee_ctrl_word[sepm_pkg::EE_DOE_BIT]  = st.ee_doe;
		strap_word = 32'h0000_0000;
		strap_word[sepm_pkg::ST_SPEED_BIT]  = st.strap.speed_100;
		strap_word[sepm_pkg::ST_DUPLEX_BIT] = st.strap.full_duplex;
		strap_word[sepm_pkg::ST_ANEG_BIT]   = st.strap.aneg_en;
		strap_word[sepm_pkg::ST_WIDTH_BIT]  = st.strap.width_32;
		strap_word[sepm_pkg::ST_VALID_BIT]  = st.strap.valid;
		pin_stat_word = 32'h0000_0000;
		// shared data pin read as input only in the EEPROM role
		// Data input bit reads only in the EEPROM role, zero otherwise
		pin_stat_word[0] = st.din_sync[1] &&
			(st.data_mode == sepm_pkg::SEPM_DATA_EEPROM);
		pin_stat_word[1] = st.pins.eeprom_select;
		pin_stat_word[2] = st.pins.eeprom_serial_clock;
		pin_stat_word[3] = st.pins.data_out;
		pin_stat_word[4] = st.pins.data_oe;
	end

	// Next-state logic: besides the read views above, the whole block is this one process plus the state
	// register below. Later assignments in the process win over earlier ones,
	// which is how the strap gate and the reset override the pin decode.
	always_comb begin
		logic        sel_block;  // Alternate role on either pin
		sel_block = 1'b0;
		next_st   = st;

		// Straps and the data line come from board pins with no relation to
		// aclk. Two flip-flops each keep a metastable level out of the capture
		// logic. Reset clears the chains, so capture waits for fresh samples.
		// rst_seen counts the first two edges after release.
		// Synchronisers for the pins
		next_st.spd_sync = {st.spd_sync[0], speed_strap};
		next_st.wid_sync = {st.wid_sync[0], bus_width_strap};
		next_st.din_sync = {st.din_sync[0], eeprom_data_io_i};
		next_st.rst_seen = {st.rst_seen[0], 1'b1};

		// Capture happens exactly once per reset: the valid flag closes the
		// gate, so later strap pin changes are ignored until the next reset.
		// Duplex is half for both speed strap levels.
		// Hazard: the width strap shares the data line, so nothing may drive
		// that line before this capture is done (see the output gate below).
		// capture once after release
		if (st.rst_seen[1] && !st.strap.valid) begin
			next_st.strap.speed_100   = st.spd_sync[1];
			next_st.strap.full_duplex = 1'b0;
			next_st.strap.aneg_en     = st.spd_sync[1];
			next_st.strap.width_32    = st.wid_sync[1];
			next_st.strap.valid       = 1'b1;
		end

		// Write side: address and data are each held in a one-deep slot, in
		// either order. Ready drops while a slot is full. The write is done
		// from the slots at the next edge, which keeps the decode off the bus
		// inputs. A new write waits until the previous response is taken.
		// Write address channel
		if (s_axi_awvalid && !st.aw_held) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		// Write data channel
		if (s_axi_wvalid && !st.w_held) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		// Perform the write once both halves are held
		if (st.aw_held && st.w_held && !st.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = sepm_pkg::RESP_OKAY;
			unique case (st.aw_addr)
				sepm_pkg::OFF_PIN_CTRL: begin
					if (st.w_strb[0]) begin
						next_st.data_mode = sepm_pkg::sepm_data_mode_t'(
							st.w_data[sepm_pkg::DATA_MODE_LSB +: 2]);
						next_st.clk_mode  = sepm_pkg::sepm_clk_mode_t'(
							st.w_data[sepm_pkg::CLK_MODE_LSB +: 2]);
					end
					if (st.w_strb[1]) begin
						next_st.general_output_3 = st.w_data[sepm_pkg::GENERAL_OUTPUT_3_BIT];
						next_st.general_output_4 = st.w_data[sepm_pkg::GENERAL_OUTPUT_4_BIT];
					end
				end
				sepm_pkg::OFF_EE_CTRL: begin
					if (st.w_strb[0]) begin
						next_st.ee_sel  = st.w_data[sepm_pkg::EE_SEL_BIT];
						next_st.ee_clk  = st.w_data[sepm_pkg::EE_CLK_BIT];
						next_st.ee_dout = st.w_data[sepm_pkg::EE_DOUT_BIT];
						next_st.ee_doe  = st.w_data[sepm_pkg::EE_DOE_BIT];
					end
				end
				// Status registers are read-only
				sepm_pkg::OFF_STRAP_STAT,
				sepm_pkg::OFF_PIN_STAT: begin
					next_st.bresp = sepm_pkg::RESP_OKAY;
				end
				default: begin
					next_st.bresp = sepm_pkg::RESP_SLVERR;
				end
			endcase
		end
		// Write response handshake
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		// Read side: the address is decoded at the edge that takes it, and the
		// word stands in rdata until the master takes it. Address ready is the
		// inverse of rvalid, so only one read is ever open.
		// Read channel: one outstanding read
		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = sepm_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				sepm_pkg::OFF_PIN_CTRL:   next_st.rdata = pin_ctrl_word;
				sepm_pkg::OFF_STRAP_STAT: next_st.rdata = strap_word;
				sepm_pkg::OFF_EE_CTRL:    next_st.rdata = ee_ctrl_word;
				sepm_pkg::OFF_PIN_STAT:   next_st.rdata = pin_stat_word;
				default: begin
					next_st.rdata = 32'h0000_0000;
					next_st.rresp = sepm_pkg::RESP_SLVERR;
				end
			endcase
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end

		// Pin roles. Any alternate role on either shared pin blocks the memory
		// select, because a monitor or general output toggling clock or data
		// would otherwise clock stray commands into the memory.
		// The general outputs have no input path at all: the clock pin always
		// drives, the data pin once the straps are latched, and the input status bit reads zero there.
		// either pin role blocks select
		sel_block = (st.data_mode != sepm_pkg::SEPM_DATA_EEPROM) ||
			(st.clk_mode != sepm_pkg::SEPM_CLK_EEPROM);

		next_st.pins.eeprom_select = st.ee_sel && !sel_block;

		unique case (st.clk_mode)
			sepm_pkg::SEPM_CLK_EEPROM: next_st.pins.eeprom_serial_clock = st.ee_clk;
			sepm_pkg::SEPM_CLK_GPO:    next_st.pins.eeprom_serial_clock = st.general_output_4;
			sepm_pkg::SEPM_CLK_RXDV:   next_st.pins.eeprom_serial_clock = mii.rx_dv;
			sepm_pkg::SEPM_CLK_RXCLK:  next_st.pins.eeprom_serial_clock = mii.rx_clk;
		endcase

		// data pin roles; alternates drive once straps are latched
		unique case (st.data_mode)
			sepm_pkg::SEPM_DATA_EEPROM: begin
				next_st.pins.data_out = st.ee_dout;
				next_st.pins.data_oe  = st.ee_doe;
			end
			sepm_pkg::SEPM_DATA_GPO: begin
				next_st.pins.data_out = st.general_output_3;
				next_st.pins.data_oe  = 1'b1;
			end
			sepm_pkg::SEPM_DATA_TXEN: begin
				next_st.pins.data_out = mii.tx_en;
				next_st.pins.data_oe  = 1'b1;
			end
			sepm_pkg::SEPM_DATA_TXCLK: begin
				next_st.pins.data_out = mii.tx_clk;
				next_st.pins.data_oe  = 1'b1;
			end
		endcase
		if (!st.strap.valid) begin
			next_st.pins.data_oe = 1'b0;
		end

		// Reset is synchronous and takes priority over everything above.
		// Roles come back as memory roles and the select goes inactive; the
		// data line is released so the width strap can be read at the end.
		// Reset clears everything
		if (!aresetn) begin
			next_st = '0;
			next_st.data_mode = sepm_pkg::sepm_data_mode_t'(
				sepm_pkg::PIN_CTRL_RST[sepm_pkg::DATA_MODE_LSB +: 2]);
			next_st.clk_mode  = sepm_pkg::sepm_clk_mode_t'(
				sepm_pkg::PIN_CTRL_RST[sepm_pkg::CLK_MODE_LSB +: 2]);
			next_st.ee_sel    = sepm_pkg::EE_CTRL_RST[sepm_pkg::EE_SEL_BIT];
		end
	end

	// State register, synchronous reset folded into next_st
	always_ff @(posedge aclk) begin
		st <= next_st;
	end

	// Write ready signals are the inverse of the held flags, arready of rvalid; everything else is a
	// plain copy of a state bit, so no output has a combinational path from
	// any input of the block.
	// Outputs
	assign s_axi_awready       = !st.aw_held;
	assign s_axi_wready        = !st.w_held;
	assign s_axi_bvalid        = st.bvalid;
	assign s_axi_bresp         = st.bresp;
	assign s_axi_arready       = !st.rvalid;
	assign s_axi_rvalid        = st.rvalid;
	assign s_axi_rdata         = st.rdata;
	assign s_axi_rresp         = st.rresp;
	assign eeprom_select       = st.pins.eeprom_select;
	assign eeprom_serial_clock = st.pins.eeprom_serial_clock;
	assign eeprom_data_io_o    = st.pins.data_out;
	assign eeprom_data_io_oe   = st.pins.data_oe;
	assign strap               = st.strap;

endmodule // sepm_top

`default_nettype wire

/* logic/sepm_pkg.sv */
// Package for the strap and EEPROM pin multiplexer.
// Assumes one 100 MHz clock and an AXI4-Lite register bus with 32-bit data.
`default_nettype none

package sepm_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_PIN_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STRAP_STAT = 8'h04;
	localparam logic [7:0] OFF_EE_CTRL    = 8'h08;
	localparam logic [7:0] OFF_PIN_STAT   = 8'h0c;

	// Pin control field positions
	localparam int DATA_MODE_LSB = 0;
	localparam int CLK_MODE_LSB  = 4;
	localparam int GENERAL_OUTPUT_3_BIT      = 8;
	localparam int GENERAL_OUTPUT_4_BIT      = 9;

	// EEPROM control field positions
	localparam int EE_SEL_BIT  = 0;
	localparam int EE_CLK_BIT  = 1;
	localparam int EE_DOUT_BIT = 2;
	localparam int EE_DOE_BIT  = 3;

	// Strap status field positions
	localparam int ST_SPEED_BIT  = 0;
	localparam int ST_DUPLEX_BIT = 1;
	localparam int ST_ANEG_BIT   = 2;
	localparam int ST_WIDTH_BIT  = 3;
	localparam int ST_VALID_BIT  = 4;

	// Reset values
	localparam logic [31:0] PIN_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] EE_CTRL_RST  = 32'h0000_0000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Role of the shared data pin
	typedef enum logic [1:0] {
		SEPM_DATA_EEPROM,
		SEPM_DATA_GPO,
		SEPM_DATA_TXEN,
		SEPM_DATA_TXCLK
	} sepm_data_mode_t;

	// Role of the shared clock pin
	typedef enum logic [1:0] {
		SEPM_CLK_EEPROM,
		SEPM_CLK_GPO,
		SEPM_CLK_RXDV,
		SEPM_CLK_RXCLK
	} sepm_clk_mode_t;

	// Latched power-up defaults
	typedef struct packed {
		logic valid;
		logic width_32;
		logic aneg_en;
		logic full_duplex;
		logic speed_100;
	} sepm_strap_t;

	// Internal MII monitor sources
	typedef struct packed {
		logic tx_en;
		logic tx_clk;
		logic rx_dv;
		logic rx_clk;
	} sepm_mii_t;

	// Shared pin drives
	typedef struct packed {
		logic eeprom_select;
		logic eeprom_serial_clock;
		logic data_out;
		logic data_oe;
	} sepm_pins_t;

endpackage

`default_nettype wire

/* sim/sepm_props.sv */
// Checker for strap capture, data pin gating and the register bus handshake.
// Bound to sepm_top at the foot of this file; sees its ports only.
`timescale 1ns/10ps
`default_nettype none

module sepm_props (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic                  s_axi_wvalid,
	input wire logic                  s_axi_wready,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic                  s_axi_rready,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic                  s_axi_rvalid,
	input wire logic                  speed_strap,
	input wire logic                  bus_width_strap,
	input wire logic                  eeprom_data_io_oe,
	input wire sepm_pkg::sepm_strap_t strap
);
	// Sampled on the bus clock, silent while reset is low
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Both write halves taken at one edge
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Response one edge after both halves are held
	sequence s_wr_answer;
		##1 s_axi_bvalid;
	endsequence
	// Read address taken
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	AST_STRAP_MAP: assert property (strap.valid |-> strap.aneg_en == strap.speed_100 && !strap.full_duplex)
		else $error("strap defaults inconsistent");
	AST_STRAP_SPEED: assert property ($rose(strap.valid) |-> strap.speed_100 == speed_strap)
		else $error("speed strap latched wrong");
	AST_STRAP_WIDTH: assert property ($rose(strap.valid) |-> strap.width_32 == bus_width_strap)
		else $error("width strap latched wrong");
	AST_STRAP_HOLD: assert property (strap.valid |=> $stable(strap))
		else $error("latched straps changed");
	AST_STRAP_SOON: assert property ($rose(aresetn) |-> ##[1:4] strap.valid)
		else $error("straps not latched after release");
	AST_OE_GATE: assert property (!strap.valid |-> !eeprom_data_io_oe)
		else $error("data pin driven before capture");
	AST_WR_RESP: assert property (s_wr_taken |=> s_wr_answer)
		else $error("write response missing");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped early");
	AST_RD_RESP: assert property (s_ar_taken |=> s_axi_rvalid)
		else $error("read data missing");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while busy");
endmodule // sepm_props

bind sepm_top sepm_props u_props (.*);

`default_nettype wire

/* sim/sepm_far_model.sv */
// Board side: strap resistors and a serial memory on the shared pins.
// Assumes the device resolves nothing; this model forms the line level.
`timescale 1ns/10ps
`default_nettype none

module sepm_far_model (
	input  wire logic eeprom_select,
	input  wire logic eeprom_data_io_o,
	input  wire logic eeprom_data_io_oe,
	input  wire logic speed_pull,
	input  wire logic width_pull,
	output logic      speed_strap,
	output logic      bus_width_strap,
	output logic      eeprom_data_io_i
);
	// Memory answers a ready bit while selected and the device listens
	logic mem_drive;
	assign mem_drive = eeprom_select && !eeprom_data_io_oe;
	// shared data line
	// Device first, then memory, else the strap resistor pull
	assign eeprom_data_io_i = eeprom_data_io_oe ? eeprom_data_io_o :
		(mem_drive ? 1'b1 : width_pull);
	// width strap
	// The width strap sits on the data line itself
	assign bus_width_strap = eeprom_data_io_i;
	assign speed_strap = speed_pull;
endmodule // sepm_far_model

`default_nettype wire

/* sim/tb_strap_and_eeprom_pin_mux.sv */
// Testbench for the strap and memory pin multiplexer.
// Assumes the board model in sepm_far_model and the bound checker.
`timescale 1ns/10ps
`default_nettype none

module tb_strap_and_eeprom_pin_mux;
	logic                  aclk = 1'b0;
	logic                  aresetn = 1'b0;
	logic [7:0]            s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]           s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]            s_axi_wstrb = 4'hf;
	logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic                  s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	logic                  speed_strap, bus_width_strap, eeprom_data_io_i, eeprom_data_io_o;
	logic                  eeprom_data_io_oe, eeprom_serial_clock, eeprom_select;
	logic                  speed_pull = 1'b0, width_pull = 1'b0;
	sepm_pkg::sepm_mii_t   mii = '0;
	sepm_pkg::sepm_strap_t strap;
	int                    err_count = 0, total_checks = 0;

	sepm_top u_dut (.*);
	sepm_far_model u_far (.*);

	// 100 MHz bus clock
	initial begin
		forever #5 aclk = ~aclk;
	end

	// Compare one result, report a mismatch at once
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Counts and verdict, then stop
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Latched strap word as the status register shows it
	function automatic logic [31:0] strap_word(input logic sp, input logic wd);
		return {27'h0, 1'b1, wd, sp, 1'b0, sp};
	endfunction

	// Register write; address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 40) begin
			err_count++;
			test_done();
		end
		chk(32'(s_axi_bresp), 32'(er));
	endtask

	// Register read with expected data and response
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 40) begin
			err_count++;
			test_done();
		end
		chk(s_axi_rdata, ed);
		chk(32'(s_axi_rresp), 32'(er));
	endtask

	// Reset with given strap pulls, held stable across release
	task automatic t_strap(input logic sp, input logic wd);
		aresetn <= 1'b0;
		speed_pull <= sp;
		width_pull <= wd;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(32'(eeprom_data_io_oe), 32'h0);
		chk(32'(strap.valid), 32'h0);
		repeat (4) @(posedge aclk);
		chk(32'(strap), strap_word(sp, wd));
		axi_rd(sepm_pkg::OFF_STRAP_STAT, strap_word(sp, wd), sepm_pkg::RESP_OKAY);
		axi_rd(sepm_pkg::OFF_PIN_CTRL, sepm_pkg::PIN_CTRL_RST, sepm_pkg::RESP_OKAY);
		axi_rd(sepm_pkg::OFF_EE_CTRL, sepm_pkg::EE_CTRL_RST, sepm_pkg::RESP_OKAY);
		chk(32'(eeprom_data_io_oe), 32'h0);
		$display("strap test done");
	endtask

	// Unmapped place and read-only status
	task automatic t_bus;
		axi_rd(8'h10, 32'h0, sepm_pkg::RESP_SLVERR);
		axi_wr(8'h10, 32'hffff_ffff, sepm_pkg::RESP_SLVERR);
		axi_wr(sepm_pkg::OFF_STRAP_STAT, 32'h0, sepm_pkg::RESP_OKAY);
		axi_rd(sepm_pkg::OFF_STRAP_STAT, strap_word(1'b1, 1'b0), sepm_pkg::RESP_OKAY);
		$display("bus test done");
	endtask

	// Default memory roles: select, clock, listen, then drive
	task automatic t_eeprom;
		axi_wr(sepm_pkg::OFF_EE_CTRL, 32'h0000_0003, sepm_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(32'(eeprom_select), 32'h1);
		chk(32'(eeprom_serial_clock), 32'h1);
		axi_rd(sepm_pkg::OFF_PIN_STAT, 32'h0000_0007, sepm_pkg::RESP_OKAY);
		axi_wr(sepm_pkg::OFF_EE_CTRL, 32'h0000_000d, sepm_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(32'(eeprom_serial_clock), 32'h0);
		chk({30'h0, eeprom_data_io_oe, eeprom_data_io_o}, 32'h3);
		$display("memory test done");
	endtask

	// Alternate roles of both pins with both source levels
	task automatic t_roles;
		logic dexp;  // Expected data pin level
		logic cexp;  // Expected clock pin level
		for (int r = 1; r < 4; r++) begin
			for (int v = 0; v < 2; v++) begin
				mii <= {v[0], ~v[0], v[0], ~v[0]};
				axi_wr(sepm_pkg::OFF_PIN_CTRL, {22'h0, v[0], ~v[0], 2'b00, 2'(r), 2'b00, 2'(r)},
					sepm_pkg::RESP_OKAY);
				repeat (3) @(posedge aclk);
				dexp = (r == 2) ? v[0] : ~v[0];
				cexp = (r == 3) ? ~v[0] : v[0];
				chk(32'(eeprom_data_io_o), 32'(dexp));
				chk(32'(eeprom_serial_clock), 32'(cexp));
				chk(32'(eeprom_data_io_oe), 32'h1);
				chk(32'(eeprom_select), 32'h0);
				axi_rd(sepm_pkg::OFF_PIN_STAT, {27'h0, 1'b1, dexp, cexp, 2'b00},
					sepm_pkg::RESP_OKAY);
			end
		end
		axi_wr(sepm_pkg::OFF_PIN_CTRL, 32'h0000_0001, sepm_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(32'(eeprom_select), 32'h0);
		axi_wr(sepm_pkg::OFF_PIN_CTRL, 32'h0000_0010, sepm_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(32'(eeprom_select), 32'h0);
		axi_wr(sepm_pkg::OFF_PIN_CTRL, 32'h0000_0000, sepm_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(32'(eeprom_select), 32'h1);
		$display("role test done");
	endtask

	// Main sequence, both strap levels each
	initial begin
		t_strap(1'b0, 1'b1);
		t_strap(1'b1, 1'b0);
		t_bus();
		t_eeprom();
		t_roles();
		test_done();
	end
endmodule // tb_strap_and_eeprom_pin_mux

`default_nettype wire
